// *** hw/ebw_consts.svh ***
// Constants for the external bus wait and release controller.
// Assumes inclusion by bare name from hw/ on the include path.
`ifndef EBW_CONSTS_SVH
`define EBW_CONSTS_SVH

// Processor clock period in ns, one T phase per clock
`define EBW_CLK_PERIOD_NS 10
// Release counter end value; grant comes 3 T states after release of the pins
`define EBW_GRANT_DLY 2'h2
// Width of the programmed wait-state count
`define EBW_WS_W 4
// Data bus width
`define EBW_DATA_W 16
// Reset levels of the strobes and selects (deasserted)
`define EBW_PIN_IDLE 1'b1

`endif

// *** hw/ebw_pkg.sv ***
// Types for the external bus wait and release controller.
// Assumes ebw_consts.svh is on the include path.
package ebw_pkg;

    // Bus phase, one clock per T state
    typedef enum logic [2:0] {
        PH_IDLE = 3'b000,
        PH_T0 = 3'b001,
        PH_T1 = 3'b010,
        PH_T2 = 3'b011,
        PH_T3 = 3'b100
    } ebw_phase_type;

    // Bus ownership
    typedef enum logic [1:0] {
        ARB_OWN = 2'b00,
        ARB_REL = 2'b01,
        ARB_GNT = 2'b10
    } ebw_arb_type;

endpackage

// *** hw/ebw_bus_ctrl.sv ***
// External bus controller: T0-T3 sequencing, wait states, bus release.
// Assumes a core request port on the same clock; bus pins are async.
`timescale 1ns/100ps
`default_nettype none
`include "ebw_consts.svh"

// Functional notes
// RULE1 - R/W set in T0: high read, low write
// RULE2 - R/W timed like address lines, early write
// RULE3 - No external access: R/W high at T0
// RULE4 - Sample transfer ack during bus activity
// RULE5 - Zero programmed waits: end 2T after ack
// RULE6 - Waits are max of programmed and ack
// RULE7 - Keep sampling ack while count decrements
// RULE8 - Early ack still waits out programmed count
// RULE9 - Count done without ack: wait for ack
// RULE10 - Partner drives ack high in prior T3
// RULE11 - Ack low at T0, zero count: no waits
// RULE12 - Ignore ack when bus is idle
// RULE13 - After reset, bus request is input, slave
// RULE14 - Grant after few T states, release early
// RULE15 - Release tri-states strobes, selects, busy
// RULE16 - External access stalls while bus granted
// RULE17 - Regain bus after request and busy deasserted
// RULE18 - No interrupt service while stalled for bus
// RULE19 - No release during read-modify-write
// RULE20 - Read strobe low T1, data captured T3
// RULE21 - Write strobe T1, data from T2, off T3
// RULE22 - External access line high on grant, reset
// RULE23 - Master holds request, then drops request, busy
// RULE24 - Grant held for tenure, dropped on retake
module ebw_bus_ctrl (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst_b,
    // Core access request
    input wire logic i_acc_req,
    input wire logic i_acc_write,
    input wire logic i_acc_prog,
    input wire logic i_acc_periph,
    input wire logic i_rmw,
    input wire logic [`EBW_WS_W-1:0] i_wait_cnt,
    input wire logic [`EBW_DATA_W-1:0] i_wdata,
    output logic o_acc_done,
    output logic [`EBW_DATA_W-1:0] o_rdata,
    output logic o_stall,
    output logic o_irq_block,
    // Bus pins, inputs
    input wire logic i_transfer_ack_n,
    input wire logic i_bus_request_n,
    input wire logic i_bus_busy_n,
    input wire logic [`EBW_DATA_W-1:0] i_data,
    // Bus pins, outputs and enables
    output logic o_bus_grant_n,
    output logic o_bus_busy_n,
    output logic o_bus_busy_n_oe,
    output logic o_external_access_n,
    output logic o_rw,
    output logic o_rw_oe,
    output logic o_peripheral_select_n,
    output logic o_peripheral_select_n_oe,
    output logic o_program_data_select,
    output logic o_program_data_select_oe,
    output logic o_rd_n,
    output logic o_rd_n_oe,
    output logic o_wr_n,
    output logic o_wr_n_oe,
    output logic [`EBW_DATA_W-1:0] o_data,
    output logic o_data_oe
);
    import ebw_pkg::*;

    function automatic logic ph_busy(input ebw_phase_type ph);
        ph_busy = (ph != PH_IDLE);
    endfunction

    function automatic logic ph_strobe(input ebw_phase_type ph);
        ph_strobe = (ph == PH_T1) || (ph == PH_T2);
    endfunction

    // Pin synchronisers
    logic [2:0] sync1_q;
    logic [2:0] sync2_q;
    logic [`EBW_DATA_W-1:0] din1_q;
    logic [`EBW_DATA_W-1:0] din2_q;
    wire ta_s = sync2_q[0];
    wire br_s = sync2_q[1];
    wire bb_s = sync2_q[2];

    ebw_phase_type ph_q, ph_d;
    ebw_arb_type arb_q, arb_d;
    logic [`EBW_WS_W-1:0] wcnt_q, wcnt_d;
    logic [1:0] gcnt_q;
    logic ta_ok_q;
    logic acc_wr_q;
    logic acc_prog_q;
    logic acc_per_q;
    logic [`EBW_DATA_W-1:0] wdata_q;

    // Ack counts only while a bus cycle runs
    wire ta_hit = ph_busy(ph_q) && !ta_s; // [RULE4] [RULE12]
    wire ta_ok_w = ta_ok_q || ta_hit; // [RULE7]
    wire ws_left = (wcnt_q != '0);
    wire owned = (arb_q == ARB_OWN);
    // Release only between bus cycles and outside read-modify-write
    wire rel_go = owned && !br_s && !ph_busy(ph_q) && !i_rmw; // [RULE19]
    wire accept = owned && !ph_busy(ph_q) && i_acc_req && !rel_go;
    // Leave wait states only when both sources are satisfied
    wire t2_exit = !ws_left && ta_ok_w; // [RULE6] [RULE8] [RULE9]
    wire gdone = (gcnt_q == `EBW_GRANT_DLY);
    wire regain = !br_s && 1'b0 || (br_s && bb_s); // [RULE17]
    wire acc_wr_d = accept ? i_acc_write : acc_wr_q;
    wire acc_prog_d = accept ? i_acc_prog : acc_prog_q;
    wire acc_per_d = accept ? i_acc_periph : acc_per_q;
    wire own_d = (arb_d == ARB_OWN);
    wire act_d = own_d && ph_busy(ph_d);

    always_comb begin
        ph_d = ph_q;
        case (ph_q)
            PH_IDLE: begin
                if (accept) begin
                    ph_d = PH_T0;
                end
            end
            PH_T0: ph_d = PH_T1;
            PH_T1: ph_d = PH_T2;
            PH_T2: begin
                if (t2_exit) begin
                    ph_d = PH_T3; // [RULE5] [RULE11]
                end
            end
            PH_T3: ph_d = PH_IDLE;
            default: ph_d = PH_IDLE;
        endcase
    end

    always_comb begin
        wcnt_d = wcnt_q;
        if (accept) begin
            wcnt_d = i_wait_cnt;
        end else if (ph_q == PH_T2 && ws_left) begin
            wcnt_d = wcnt_q - 1'b1; // [RULE7]
        end
    end

    // Slave mode only: request is always an input here
    always_comb begin
        arb_d = arb_q; // [RULE13]
        case (arb_q)
            ARB_OWN: begin
                if (rel_go) begin
                    arb_d = ARB_REL; // [RULE14]
                end
            end
            ARB_REL: begin
                if (gdone) begin
                    arb_d = ARB_GNT;
                end
            end
            ARB_GNT: begin
                if (regain) begin
                    arb_d = ARB_OWN; // [RULE24]
                end
            end
            default: arb_d = ARB_OWN;
        endcase
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            sync1_q <= 3'h7;
            sync2_q <= 3'h7;
            din1_q <= '0;
            din2_q <= '0;
        end else begin
            sync1_q <= {i_bus_busy_n, i_bus_request_n, i_transfer_ack_n};
            sync2_q <= sync1_q;
            din1_q <= i_data;
            din2_q <= din1_q;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            ph_q <= PH_IDLE;
            arb_q <= ARB_OWN;
            wcnt_q <= '0;
            gcnt_q <= 2'h0;
            ta_ok_q <= 1'b0;
        end else begin
            ph_q <= ph_d;
            arb_q <= arb_d;
            wcnt_q <= wcnt_d;
            gcnt_q <= (arb_q == ARB_REL) ? gcnt_q + 2'h1 : 2'h0;
            ta_ok_q <= ph_busy(ph_q) ? ta_ok_w : 1'b0; // [RULE12]
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            acc_wr_q <= 1'b0;
            acc_prog_q <= 1'b0;
            acc_per_q <= 1'b0;
            wdata_q <= '0;
        end else begin
            acc_wr_q <= acc_wr_d;
            acc_prog_q <= acc_prog_d;
            acc_per_q <= acc_per_d;
            wdata_q <= accept ? i_wdata : wdata_q;
        end
    end

    // Core side answers
    wire stall_d = i_acc_req && !owned; // [RULE16]
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_acc_done <= 1'b0;
            o_rdata <= '0;
            o_stall <= 1'b0;
            o_irq_block <= 1'b0;
        end else begin
            o_acc_done <= (ph_q == PH_T3);
            if (ph_q == PH_T3 && !acc_wr_q) begin
                o_rdata <= din2_q; // [RULE20]
            end
            o_stall <= stall_d;
            o_irq_block <= stall_d; // [RULE18]
        end
    end

    // Pin outputs, registered from the next state
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_bus_grant_n <= `EBW_PIN_IDLE;
            o_bus_busy_n <= `EBW_PIN_IDLE;
            o_bus_busy_n_oe <= 1'b0;
            o_external_access_n <= `EBW_PIN_IDLE; // [RULE22]
            o_rw <= `EBW_PIN_IDLE;
            o_rw_oe <= 1'b0;
            o_peripheral_select_n <= `EBW_PIN_IDLE;
            o_peripheral_select_n_oe <= 1'b0;
            o_program_data_select <= `EBW_PIN_IDLE;
            o_program_data_select_oe <= 1'b0;
            o_rd_n <= `EBW_PIN_IDLE;
            o_rd_n_oe <= 1'b0;
            o_wr_n <= `EBW_PIN_IDLE;
            o_wr_n_oe <= 1'b0;
            o_data <= '0;
            o_data_oe <= 1'b0;
        end else begin
            o_bus_grant_n <= (arb_d != ARB_GNT); // [RULE14] [RULE24]
            o_bus_busy_n <= !own_d;
            o_bus_busy_n_oe <= own_d; // [RULE15]
            o_external_access_n <= !act_d; // [RULE22]
            o_rw <= !(act_d && acc_wr_d); // [RULE1] [RULE2] [RULE3]
            o_rw_oe <= own_d; // [RULE15]
            o_peripheral_select_n <= !(act_d && acc_per_d && !acc_prog_d);
            o_peripheral_select_n_oe <= own_d;
            o_program_data_select <= !act_d || acc_prog_d;
            o_program_data_select_oe <= own_d;
            o_rd_n <= !(own_d && ph_strobe(ph_d) && !acc_wr_d); // [RULE20]
            o_rd_n_oe <= own_d;
            o_wr_n <= !(own_d && ph_strobe(ph_d) && acc_wr_d); // [RULE21]
            o_wr_n_oe <= own_d;
            o_data <= wdata_q;
            o_data_oe <= own_d && acc_wr_d &&
                ((ph_d == PH_T2) || (ph_d == PH_T3)); // [RULE21]
        end
    end

    // Checks
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_rst_b);

    sequence seq_tail;
        ph_q == PH_T3 ##1 ph_q == PH_IDLE && o_acc_done;
    endsequence

    sequence seq_no_wait;
        ph_q == PH_T1 ##1 ph_q == PH_T2 ##1 seq_tail;
    endsequence

    rw_t0_level_a: assert property ( // [RULE1]
        ph_q == PH_T0 |-> o_rw == !acc_wr_q && !o_external_access_n)
        else $error("R/W wrong in T0");
    rw_idle_high_a: assert property ( // [RULE3]
        ph_q == PH_IDLE && owned |-> o_rw)
        else $error("R/W not high without access");
    ta_ignored_a: assert property ( // [RULE12]
        ph_q == PH_IDLE |=> !ta_ok_q)
        else $error("Ack remembered outside a bus cycle");
    ws_count_a: assert property ( // [RULE8]
        ph_q == PH_T2 && ws_left |=> ph_q == PH_T2 &&
        wcnt_q == $past(wcnt_q) - 1'b1)
        else $error("Programmed wait not honoured");
    ta_wait_a: assert property ( // [RULE9]
        ph_q == PH_T2 && !ws_left && !ta_ok_w |=> ph_q == PH_T2)
        else $error("Cycle ended without ack");
    ta_end_a: assert property ( // [RULE5]
        ph_q == PH_T2 && t2_exit |=> seq_tail)
        else $error("Cycle not ended 2T after ack");
    zero_ws_a: assert property ( // [RULE11]
        ph_q == PH_T0 && !ta_s && i_wait_cnt == '0 && wcnt_q == '0
        |=> seq_no_wait)
        else $error("Wait inserted with ack at T0");
    grant_delay_a: assert property ( // [RULE14]
        rel_go |=> o_bus_busy_n_oe == 1'b0 ##[1:4] !o_bus_grant_n)
        else $error("Grant not given in time");
    release_pins_a: assert property ( // [RULE15]
        !o_bus_grant_n |-> !o_rw_oe && !o_rd_n_oe && !o_wr_n_oe &&
        !o_bus_busy_n_oe && o_external_access_n)
        else $error("Pins driven while granted");
    regain_cond_a: assert property ( // [RULE17]
        $rose(o_bus_grant_n) |-> $past(br_s) && $past(bb_s))
        else $error("Bus taken back too early");
    rmw_hold_a: assert property ( // [RULE19]
        owned && i_rmw |=> owned)
        else $error("Bus released during read-modify-write");
    stall_a: assert property ( // [RULE16]
        !owned && i_acc_req |=> o_stall && o_irq_block &&
        ph_q == PH_IDLE)
        else $error("Access not stalled while granted");
    strobe_t1_a: assert property ( // [RULE20]
        ph_q == PH_T1 && owned |-> o_rd_n == acc_wr_q &&
        o_wr_n == !acc_wr_q)
        else $error("Strobe timing wrong");
    // Wait states may stretch T2, so strobe release is checked at T3
    strobe_t3_a: assert property ( // [RULE21]
        ph_q == PH_T3 |-> o_rd_n && o_wr_n)
        else $error("Strobe still low in T3");
    wdata_window_a: assert property ( // [RULE21]
        o_data_oe |-> acc_wr_q && (ph_q == PH_T2 || ph_q == PH_T3))
        else $error("Write data driven outside T2 and T3");
    rdata_take_a: assert property ( // [RULE20]
        ph_q == PH_T3 && !acc_wr_q |=> o_rdata == $past(din2_q))
        else $error("Read data not taken at T3");
    grant_hold_a: assert property ( // [RULE24]
        !o_bus_grant_n && !(br_s && bb_s) |=> !o_bus_grant_n)
        else $error("Grant dropped during external tenure");
endmodule
`default_nettype wire

// *** testbench/ebw_far_end.sv ***
// Far-side model: memory with a settable ack delay, and a second master.
// Assumes the bench resolves the busy line with a pull-up.
`timescale 1ns/100ps
`default_nettype none
`include "ebw_consts.svh"
module ebw_far_end (
    // Clock
    input wire logic i_clk,
    // Lines from the controller
    input wire logic i_access_n,
    input wire logic i_rd_n,
    input wire logic i_wr_n,
    input wire logic i_grant_n,
    input wire logic i_data_oe,
    input wire logic [`EBW_DATA_W-1:0] i_wdata,
    // Bench controls
    input wire logic [3:0] i_ack_dly,
    input wire logic [`EBW_DATA_W-1:0] i_mem,
    input wire logic i_claim,
    input wire logic i_hold,
    // Lines to the controller
    output logic o_ack_n,
    output logic o_request_n,
    output logic o_busy_low,
    output logic [`EBW_DATA_W-1:0] o_data,
    output logic [`EBW_DATA_W-1:0] o_wr_seen
);
    int cnt = 0;
    initial begin
        o_request_n = 1'b1;
        o_busy_low = 1'b0;
        o_wr_seen = 16'h0000;
    end
    // Memory drives while the read strobe is low; released lines show the
    // inverse so stale values cannot pass
    assign o_data = i_rd_n ? ~i_mem : i_mem;
    // Delay zero keeps ack low even while idle
    assign o_ack_n = (i_ack_dly == 0) ? 1'b0 :
        !(!i_access_n && cnt >= i_ack_dly);
    always @(posedge i_clk) begin
        cnt <= i_access_n ? 0 : cnt + 1;
        if (!i_wr_n && i_data_oe)
            o_wr_seen <= i_wdata;
        o_request_n <= !i_claim;
        if (!i_grant_n && i_hold)
            o_busy_low <= 1'b1;
        else if (!i_hold)
            o_busy_low <= 1'b0;
    end
endmodule
`default_nettype wire

// *** testbench/ebw_bus_ctrl_tb_top.sv ***
// Bench for the bus controller: random accesses, wait states, release.
// Assumes the far-side model and a pull-up on the busy line.
`timescale 1ns/100ps
`default_nettype none
`include "ebw_consts.svh"
module ebw_bus_ctrl_tb_top;
    logic i_ref_clk = 0;
    logic i_rst_b = 0;
    logic req = 0, wr = 0, prog = 0, per = 0, rmw = 0, claim = 0, hold = 0;
    logic [`EBW_WS_W-1:0] ws = 0;
    logic [3:0] dly = 0;
    logic [`EBW_DATA_W-1:0] wd = 0, mem = 0, din, dout, rdata, wseen;
    logic done, stall, irqb, gnt_n, busy_n, busy_oe, acc_n, rw, rw_oe;
    logic psel_n, psel_oe, pds, pds_oe, rd_n, rd_oe, wr_n, wr_oe, d_oe;
    logic ack_n, req_n, busy_low, prev_acc_n = 1;
    wire busy_pin = !((busy_oe && !busy_n) || busy_low);
    int mismatches = 0, n_compared = 0;
    int seed = 32'hb5a3723d;
    always #5 i_ref_clk = !i_ref_clk;
    ebw_bus_ctrl i_ebw_bus_ctrl (.i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b),
        .i_acc_req(req), .i_acc_write(wr), .i_acc_prog(prog),
        .i_acc_periph(per), .i_rmw(rmw), .i_wait_cnt(ws), .i_wdata(wd),
        .o_acc_done(done), .o_rdata(rdata), .o_stall(stall),
        .o_irq_block(irqb), .i_transfer_ack_n(ack_n),
        .i_bus_request_n(req_n), .i_bus_busy_n(busy_pin), .i_data(din),
        .o_bus_grant_n(gnt_n), .o_bus_busy_n(busy_n),
        .o_bus_busy_n_oe(busy_oe), .o_external_access_n(acc_n),
        .o_rw(rw), .o_rw_oe(rw_oe), .o_peripheral_select_n(psel_n),
        .o_peripheral_select_n_oe(psel_oe), .o_program_data_select(pds),
        .o_program_data_select_oe(pds_oe), .o_rd_n(rd_n), .o_rd_n_oe(rd_oe),
        .o_wr_n(wr_n), .o_wr_n_oe(wr_oe), .o_data(dout), .o_data_oe(d_oe));
    ebw_far_end i_ebw_far_end (.i_clk(i_ref_clk), .i_access_n(acc_n),
        .i_rd_n(rd_n), .i_wr_n(wr_n), .i_grant_n(gnt_n), .i_data_oe(d_oe),
        .i_wdata(dout), .i_ack_dly(dly), .i_mem(mem), .i_claim(claim),
        .i_hold(hold), .o_ack_n(ack_n), .o_request_n(req_n),
        .o_busy_low(busy_low), .o_data(din), .o_wr_seen(wseen));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %0t mismatch %h vs %h", $time, seen, exp);
        end
    endtask
    task automatic complete_run();
        $display("Compared %0d, mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // Four T states and the done cycle plus the larger of programmed and ack waits
    task automatic access(input int w, input int wsv, dv, slack);
        int n;
        int lo;
        int hi;
        int r;
        n = 0;
        lo = 5 + ((wsv > dv) ? wsv : dv);
        hi = lo + slack;
        wr = w[0];
        ws = wsv[3:0];
        dly = dv[3:0];
        r = $random(seed);
        prog = r[0];
        per = r[1];
        wd = r[31:16];
        r = $random(seed);
        mem = r[15:0];
        // Let a changed ack level pass the pin synchroniser first
        repeat (2) @(negedge i_ref_clk);
        req = 1;
        while (n < 80 && done !== 1'b1) begin
            @(negedge i_ref_clk);
            n++;
        end
        req = 0;
        check(n >= lo, 1);
        check(n <= hi, 1);
        check(rw, 1);
        check(w[0] ? wseen : rdata, w[0] ? wd : mem);
    endtask
    task automatic wait_gnt(input logic v);
        int n;
        n = 0;
        while (n < 20 && gnt_n !== v) begin
            @(negedge i_ref_clk);
            n++;
        end
        check(gnt_n, v);
    endtask
    always @(negedge i_ref_clk) begin
        if (i_rst_b && prev_acc_n && !acc_n) begin
            check({rw, pds, psel_n}, {!wr, prog, !(per && !prog)});
        end
        if (i_rst_b && !gnt_n) begin
            check(acc_n, 1);
            check({rw_oe, psel_oe, pds_oe, rd_oe, wr_oe, busy_oe}, 0);
        end
        if (stall)
            check(irqb, 1);
        prev_acc_n <= acc_n;
    end
    initial begin
        repeat (5) @(negedge i_ref_clk);
        check({gnt_n, acc_n, rw, rd_oe}, 4'he);
        i_rst_b = 1;
        repeat (3) @(negedge i_ref_clk);
        for (int i = 0; i < 30; i++) begin
            access($random(seed), {$random(seed)} % 8, {$random(seed)} % 7, 0);
            repeat (3) @(negedge i_ref_clk);
        end
        claim = 1;
        hold = 1;
        wait_gnt(0);
        fork
            access(1, 2, 0, 40);
            begin
                repeat (6) @(negedge i_ref_clk);
                check({stall, done}, 2'h2);
                claim = 0;
                repeat (8) @(negedge i_ref_clk);
                check(gnt_n, 0);
                hold = 0;
            end
        join
        check(gnt_n, 1);
        rmw = 1;
        claim = 1;
        hold = 1;
        repeat (10) @(negedge i_ref_clk);
        check({gnt_n, rd_oe}, 2'h3);
        rmw = 0;
        wait_gnt(0);
        claim = 0;
        hold = 0;
        wait_gnt(1);
        access(0, 0, 0, 0);
        complete_run();
    end
    initial begin
        #100000;
        mismatches++;
        complete_run();
    end
endmodule
`default_nettype wire
